// ===== hdl/pic_pkg.sv
// package: constants and carrier types for the primary interrupt controller
package pic_pkg;
   // ==========================================
   // sizes
   localparam int NUM_SRC = 40;
   localparam int ID_W = 6;
   localparam int CREG_W = 4;
   // ==========================================
   // coprocessor register numbers (space six)
   localparam logic [3:0] CP_NUM = 4'h6;
   localparam logic [3:0] CR_NORMAL_PEND = 4'h0;
   localparam logic [3:0] CR_MASK = 4'h1;
   localparam logic [3:0] CR_LEVEL = 4'h2;
   localparam logic [3:0] CR_FAST_PEND = 4'h3;
   localparam logic [3:0] CR_ALL_PEND = 4'h4;
   localparam logic [3:0] CR_HIGHEST = 4'h5;
   localparam logic [3:0] CR_NORMAL_PEND2 = 4'h6;
   localparam logic [3:0] CR_MASK2 = 4'h7;
   localparam logic [3:0] CR_LEVEL2 = 4'h8;
   localparam logic [3:0] CR_FAST_PEND2 = 4'h9;
   localparam logic [3:0] CR_ALL_PEND2 = 4'hA;
   // ==========================================
   // memory-mapped word offsets
   localparam logic [7:0] MM_NORMAL_PEND = 8'h00;
   localparam logic [7:0] MM_MASK = 8'h04;
   localparam logic [7:0] MM_LEVEL = 8'h08;
   localparam logic [7:0] MM_FAST_PEND = 8'h0C;
   localparam logic [7:0] MM_ALL_PEND = 8'h10;
   localparam logic [7:0] MM_CONTROL = 8'h14;
   localparam logic [7:0] MM_HIGHEST = 8'h18;
   localparam logic [7:0] MM_NORMAL_PEND2 = 8'h9C;
   localparam logic [7:0] MM_MASK2 = 8'hA0;
   localparam logic [7:0] MM_LEVEL2 = 8'hA4;
   localparam logic [7:0] MM_FAST_PEND2 = 8'hA8;
   localparam logic [7:0] MM_ALL_PEND2 = 8'hAC;
   localparam logic [7:0] MM_PRIO_LO_BASE = 8'h1C;
   localparam logic [7:0] MM_PRIO_HI_BASE = 8'hB0;
   localparam int PRIO_LO_COUNT = 32;
   // ==========================================
   // fields
   localparam int HP_FAST_ID_LSB = 0;
   localparam int HP_FAST_VALID_BIT = 15;
   localparam int HP_NORMAL_ID_LSB = 16;
   localparam int HP_NORMAL_VALID_BIT = 31;
   localparam int PRIO_VALID_BIT = 31;
   localparam int CTRL_IDLE_MASK_HONOUR_BIT = 0;
   // ==========================================
   // reset values and unmapped-read data
   localparam logic [NUM_SRC-1:0] MASK_RESET = 40'h00_0000_0000;
   localparam logic [NUM_SRC-1:0] LEVEL_RESET = 40'h00_0000_0000;
   localparam logic [NUM_SRC-1:0] PEND_RESET = 40'h00_0000_0000;
   localparam logic [31:0] ERR_DATA = 32'h0000_0000;

   // one register request, either path
   typedef struct packed {
      logic valid;
      logic write;
      logic coproc;
      logic supervisor;
      logic [3:0] cp_reg;
      logic [7:0] mm_offset;
      logic [31:0] wdata;
   } pic_req_type;

   typedef struct packed {
      logic done;
      logic undef_err;
      logic abort_err;
      logic [31:0] rdata;
   } pic_resp_type;

   typedef struct packed {
      logic valid;
      logic [ID_W-1:0] id;
   } pic_winner_type;
endpackage : pic_pkg

// ===== hdl/pic_prio_pick.sv
// module: picks the highest ranked active source from a priority map
`timescale 1ns/100ps
`default_nettype none
module pic_prio_pick (
   // candidates
   input wire logic [pic_pkg::NUM_SRC-1:0] active,
   // priority map, entry 0 highest
   input wire logic [pic_pkg::NUM_SRC-1:0][pic_pkg::ID_W-1:0] map_id,
   input wire logic [pic_pkg::NUM_SRC-1:0] map_valid,
   // result
   output pic_pkg::pic_winner_type winner
);
   always_comb begin
      winner = '0;
      // scan from lowest rank upward so the top rank is written last and wins
      for (int p = pic_pkg::NUM_SRC - 1; p >= 0; p--) begin
         if (map_valid[p] && (map_id[p] < pic_pkg::ID_W'(pic_pkg::NUM_SRC))
               && active[map_id[p]]) begin
            winner.valid = 1'b1;
            winner.id = map_id[p];
         end
      end
   end
endmodule : pic_prio_pick
`default_nettype wire

// ===== hdl/pic_top.sv
// module: primary interrupt controller, sources to normal and fast requests
`timescale 1ns/100ps
`default_nettype none
module pic_top (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // peripheral requests, bit index is the peripheral identifier
   input wire logic [pic_pkg::NUM_SRC-1:0] src_irq,
   // register access from the core
   input wire pic_pkg::pic_req_type req,
   output pic_pkg::pic_resp_type resp,
   // core side
   input wire logic core_idle,
   output logic normal_irq,
   output logic fast_irq,
   output logic wake
);
   // ==========================================
   // state
   logic [pic_pkg::NUM_SRC-1:0] mask_reg, mask_next;
   logic [pic_pkg::NUM_SRC-1:0] level_reg, level_next;
   logic [pic_pkg::NUM_SRC-1:0] pend_reg, pend_next;
   logic [pic_pkg::NUM_SRC-1:0][pic_pkg::ID_W-1:0] pid_reg, pid_next;
   logic [pic_pkg::NUM_SRC-1:0] pval_reg, pval_next;
   logic idle_honour_reg, idle_honour_next;
   logic [31:0] highest_reg, highest_next;
   logic normal_irq_reg, normal_irq_next;
   logic fast_irq_reg, fast_irq_next;
   logic wake_reg, wake_next;
   pic_pkg::pic_resp_type resp_reg, resp_next;

   logic [pic_pkg::NUM_SRC-1:0] normal_view;
   logic [pic_pkg::NUM_SRC-1:0] fast_view;
   pic_pkg::pic_winner_type normal_win;
   pic_pkg::pic_winner_type fast_win;

   // ==========================================
   // views from the sampled pending state
   // pending is a registered copy of the source lines, not a latch; it drops
   // one clock after the peripheral drops its request
   always_comb begin
      pend_next = src_irq;
      normal_view = pend_reg & mask_reg & ~level_reg;
      fast_view = pend_reg & mask_reg & level_reg;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pend_reg <= pic_pkg::PEND_RESET;
      end else begin
         pend_reg <= pend_next;
      end
   end

   // ==========================================
   // ranking, one picker per level
   pic_prio_pick u_pick_normal (
      .active(normal_view),
      .map_id(pid_reg),
      .map_valid(pval_reg),
      .winner(normal_win)
   );

   pic_prio_pick u_pick_fast (
      .active(fast_view),
      .map_id(pid_reg),
      .map_valid(pval_reg),
      .winner(fast_win)
   );

   // ==========================================
   // highest-priority report, refreshed every cycle from the pickers
   always_comb begin
      highest_next = '0;
      highest_next[pic_pkg::HP_NORMAL_ID_LSB +: pic_pkg::ID_W] = normal_win.id;
      highest_next[pic_pkg::HP_NORMAL_VALID_BIT] = normal_win.valid;
      highest_next[pic_pkg::HP_FAST_ID_LSB +: pic_pkg::ID_W] = fast_win.id;
      highest_next[pic_pkg::HP_FAST_VALID_BIT] = fast_win.valid;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         highest_reg <= '0;
      end else begin
         highest_reg <= highest_next;
      end
   end

   // ==========================================
   // requests to the core
   // level outputs from flops, so the core never sees a decode glitch
   always_comb begin
      normal_irq_next = |normal_view;
      fast_irq_next = |fast_view;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         normal_irq_reg <= 1'b0;
         fast_irq_reg <= 1'b0;
      end else begin
         normal_irq_reg <= normal_irq_next;
         fast_irq_reg <= fast_irq_next;
      end
   end

   // ==========================================
   // wake from idle
   // not gated by level steering: a fast-level source wakes the core too
   always_comb begin
      // masks only count in idle when software asked for it
      if (idle_honour_reg) begin
         wake_next = core_idle && (|(pend_reg & mask_reg));
      end else begin
         wake_next = core_idle && (|pend_reg);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wake_reg <= 1'b0;
      end else begin
         wake_reg <= wake_next;
      end
   end

   // ==========================================
   // register access
   function automatic logic [31:0] rd_pair(input logic [pic_pkg::NUM_SRC-1:0] v,
                                           input logic hi);
      logic [31:0] r;
      // upper word carries only the top sources, the rest reads zero
      r = '0;
      if (hi) begin
         r[pic_pkg::NUM_SRC-33:0] = v[pic_pkg::NUM_SRC-1:32];
      end else begin
         r = v[31:0];
      end
      return r;
   endfunction : rd_pair

   logic [7:0] prio_idx;
   logic prio_hit;

   // priority entries sit in two windows; other offsets fall to the register case
   always_comb begin
      prio_hit = 1'b0;
      prio_idx = '0;
      if (req.mm_offset >= pic_pkg::MM_PRIO_LO_BASE
            && req.mm_offset < 8'(pic_pkg::MM_PRIO_LO_BASE + 4 * pic_pkg::PRIO_LO_COUNT)
            && req.mm_offset[1:0] == 2'h0) begin
         prio_hit = 1'b1;
         prio_idx = 8'((req.mm_offset - pic_pkg::MM_PRIO_LO_BASE) >> 2);
      end else if (req.mm_offset >= pic_pkg::MM_PRIO_HI_BASE
            && req.mm_offset < 8'(pic_pkg::MM_PRIO_HI_BASE
               + 4 * (pic_pkg::NUM_SRC - pic_pkg::PRIO_LO_COUNT))
            && req.mm_offset[1:0] == 2'h0) begin
         prio_hit = 1'b1;
         prio_idx = 8'(((req.mm_offset - pic_pkg::MM_PRIO_HI_BASE) >> 2)
                       + pic_pkg::PRIO_LO_COUNT);
      end
   end

   always_comb begin
      mask_next = mask_reg;
      level_next = level_reg;
      pid_next = pid_reg;
      pval_next = pval_reg;
      idle_honour_next = idle_honour_reg;
      resp_next = '0;
      if (req.valid) begin
         resp_next.done = 1'b1;
         // a refused access changes nothing and reads zero
         if (!req.supervisor) begin
            resp_next.undef_err = req.coproc;
            resp_next.abort_err = !req.coproc;
         end else if (req.coproc) begin
            case (req.cp_reg)
               pic_pkg::CR_NORMAL_PEND: resp_next.rdata = rd_pair(normal_view, 1'b0);
               pic_pkg::CR_MASK: begin
                  resp_next.rdata = rd_pair(mask_reg, 1'b0);
                  if (req.write) mask_next[31:0] = req.wdata;
               end
               pic_pkg::CR_LEVEL: begin
                  resp_next.rdata = rd_pair(level_reg, 1'b0);
                  if (req.write) level_next[31:0] = req.wdata;
               end
               pic_pkg::CR_FAST_PEND: resp_next.rdata = rd_pair(fast_view, 1'b0);
               pic_pkg::CR_ALL_PEND: resp_next.rdata = rd_pair(pend_reg, 1'b0);
               pic_pkg::CR_HIGHEST: resp_next.rdata = highest_reg;
               pic_pkg::CR_NORMAL_PEND2: resp_next.rdata = rd_pair(normal_view, 1'b1);
               pic_pkg::CR_MASK2: begin
                  resp_next.rdata = rd_pair(mask_reg, 1'b1);
                  if (req.write) mask_next[pic_pkg::NUM_SRC-1:32] =
                     req.wdata[pic_pkg::NUM_SRC-33:0];
               end
               pic_pkg::CR_LEVEL2: begin
                  resp_next.rdata = rd_pair(level_reg, 1'b1);
                  if (req.write) level_next[pic_pkg::NUM_SRC-1:32] =
                     req.wdata[pic_pkg::NUM_SRC-33:0];
               end
               pic_pkg::CR_FAST_PEND2: resp_next.rdata = rd_pair(fast_view, 1'b1);
               pic_pkg::CR_ALL_PEND2: resp_next.rdata = rd_pair(pend_reg, 1'b1);
               // priority and control are not on the coprocessor path
               default: resp_next.undef_err = 1'b1;
            endcase
         end else begin
            if (prio_hit) begin
               // only the identifier field and the valid flag are stored
               resp_next.rdata[pic_pkg::ID_W-1:0] = pid_reg[prio_idx[5:0]];
               resp_next.rdata[pic_pkg::PRIO_VALID_BIT] = pval_reg[prio_idx[5:0]];
               if (req.write) begin
                  pid_next[prio_idx[5:0]] = req.wdata[pic_pkg::ID_W-1:0];
                  pval_next[prio_idx[5:0]] = req.wdata[pic_pkg::PRIO_VALID_BIT];
               end
            end else begin
               case (req.mm_offset)
                  pic_pkg::MM_NORMAL_PEND: resp_next.rdata = rd_pair(normal_view, 1'b0);
                  pic_pkg::MM_MASK: begin
                     resp_next.rdata = rd_pair(mask_reg, 1'b0);
                     if (req.write) mask_next[31:0] = req.wdata;
                  end
                  pic_pkg::MM_LEVEL: begin
                     resp_next.rdata = rd_pair(level_reg, 1'b0);
                     if (req.write) level_next[31:0] = req.wdata;
                  end
                  pic_pkg::MM_FAST_PEND: resp_next.rdata = rd_pair(fast_view, 1'b0);
                  pic_pkg::MM_ALL_PEND: resp_next.rdata = rd_pair(pend_reg, 1'b0);
                  pic_pkg::MM_CONTROL: begin
                     resp_next.rdata[pic_pkg::CTRL_IDLE_MASK_HONOUR_BIT] = idle_honour_reg;
                     if (req.write) begin
                        idle_honour_next =
                           req.wdata[pic_pkg::CTRL_IDLE_MASK_HONOUR_BIT];
                     end
                  end
                  pic_pkg::MM_HIGHEST: resp_next.rdata = highest_reg;
                  pic_pkg::MM_NORMAL_PEND2: resp_next.rdata = rd_pair(normal_view, 1'b1);
                  pic_pkg::MM_MASK2: begin
                     resp_next.rdata = rd_pair(mask_reg, 1'b1);
                     if (req.write) mask_next[pic_pkg::NUM_SRC-1:32] =
                        req.wdata[pic_pkg::NUM_SRC-33:0];
                  end
                  pic_pkg::MM_LEVEL2: begin
                     resp_next.rdata = rd_pair(level_reg, 1'b1);
                     if (req.write) level_next[pic_pkg::NUM_SRC-1:32] =
                        req.wdata[pic_pkg::NUM_SRC-33:0];
                  end
                  pic_pkg::MM_FAST_PEND2: resp_next.rdata = rd_pair(fast_view, 1'b1);
                  pic_pkg::MM_ALL_PEND2: resp_next.rdata = rd_pair(pend_reg, 1'b1);
                  // unmapped words read zero, writes dropped
                  default: resp_next.rdata = pic_pkg::ERR_DATA;
               endcase
            end
         end
      end
   end

   // ==========================================
   // registers: configuration and register answer
   always_ff @(posedge clk) begin
      if (rst) begin
         mask_reg <= pic_pkg::MASK_RESET;
         level_reg <= pic_pkg::LEVEL_RESET;
         pid_reg <= '0;
         pval_reg <= '0;
         idle_honour_reg <= 1'b0;
         resp_reg <= '0;
      end else begin
         mask_reg <= mask_next;
         level_reg <= level_next;
         pid_reg <= pid_next;
         pval_reg <= pval_next;
         idle_honour_reg <= idle_honour_next;
         resp_reg <= resp_next;
      end
   end

   assign normal_irq = normal_irq_reg;
   assign fast_irq = fast_irq_reg;
   assign wake = wake_reg;
   assign resp = resp_reg;
endmodule : pic_top
`default_nettype wire

// ===== bench/pic_top_monitor.sv
// checker: port-level properties of the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module pic_top_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // watched ports
   input wire logic [pic_pkg::NUM_SRC-1:0] src_irq,
   input wire pic_pkg::pic_req_type req,
   input wire pic_pkg::pic_resp_type resp,
   input wire logic core_idle,
   input wire logic normal_irq,
   input wire logic fast_irq,
   input wire logic wake
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ==========================================
   // register path
   AST_DONE: assert property (req.valid |=> resp.done)
      else $error("request not answered");
   AST_NO_DONE: assert property (!req.valid |=> !resp.done)
      else $error("answer without request");
   AST_UNDEF: assert property (req.valid && req.coproc && !req.supervisor
      |=> resp.undef_err && !resp.abort_err) else $error("coproc access not refused");
   AST_ABORT: assert property (req.valid && !req.coproc && !req.supervisor
      |=> resp.abort_err && !resp.undef_err) else $error("mapped access not aborted");
   AST_SUP_OK: assert property (req.valid && !req.coproc && req.supervisor
      |=> !resp.abort_err && !resp.undef_err) else $error("supervised access refused");
   AST_ERR_DATA: assert property (resp.undef_err || resp.abort_err |-> resp.rdata == 32'h0)
      else $error("refused access returned data");
   // ==========================================
   // request outputs
   AST_QUIET: assert property ((src_irq == '0)[*2] |=> !normal_irq && !fast_irq && !wake)
      else $error("request without active source");
   AST_WAKE_IDLE: assert property ((!core_idle)[*2] |=> !wake)
      else $error("wake while core not idle");
endmodule : pic_top_monitor
bind pic_top pic_top_monitor pic_top_monitor_i (.clk(clk), .rst(rst), .src_irq(src_irq),
   .req(req), .resp(resp), .core_idle(core_idle), .normal_irq(normal_irq),
   .fast_irq(fast_irq), .wake(wake));
`default_nettype wire

// ===== bench/pic_periph_model.sv
// model: peripherals folding secondary conditions into first-level requests
`timescale 1ns/100ps
`default_nettype none
module pic_periph_model (
   // secondary conditions and local enables, two per peripheral
   input wire logic [pic_pkg::NUM_SRC-1:0][1:0] sec_cond,
   input wire logic [pic_pkg::NUM_SRC-1:0][1:0] sec_en,
   // first-level requests
   output logic [pic_pkg::NUM_SRC-1:0] src_irq
);
   always_comb begin
      for (int i = 0; i < pic_pkg::NUM_SRC; i++) begin
         src_irq[i] = |(sec_cond[i] & sec_en[i]);
      end
   end
endmodule : pic_periph_model
`default_nettype wire

// ===== bench/pic_top_test.sv
// testbench: scenarios for the primary interrupt controller
`timescale 1ns/100ps
`default_nettype none
module pic_top_test;
   logic clk;
   logic rst;
   logic core_idle;
   logic [pic_pkg::NUM_SRC-1:0][1:0] sec_cond;
   logic [pic_pkg::NUM_SRC-1:0][1:0] sec_en;
   logic [pic_pkg::NUM_SRC-1:0] src_irq;
   pic_pkg::pic_req_type req;
   pic_pkg::pic_resp_type resp;
   pic_pkg::pic_resp_type rsp;
   logic normal_irq;
   logic fast_irq;
   logic wake;
   logic [31:0] rd;
   int fail_count;
   int comparisons;
   pic_periph_model pic_periph_model_i (.sec_cond(sec_cond), .sec_en(sec_en), .src_irq(src_irq));
   pic_top pic_top_i (.clk(clk), .rst(rst), .src_irq(src_irq), .req(req), .resp(resp),
      .core_idle(core_idle), .normal_irq(normal_irq), .fast_irq(fast_irq), .wake(wake));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ==========================================
   // shared tasks
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic acc(input logic wr, input logic cp, input logic sup, input logic [3:0] cr,
      input logic [7:0] off, input logic [31:0] wd);
      @(posedge clk);
      #1 req = {1'b1, wr, cp, sup, cr, off, wd};
      @(posedge clk);
      #1 rsp = resp;
      rd = resp.rdata;
      req.valid = 1'b0;
      check("done", rsp.done, 32'h1);
   endtask : acc
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask : settle
   // low condition always true but locally disabled, so only the high one counts
   task automatic drive_src(input logic [39:0] v);
      for (int i = 0; i < 40; i++) begin
         sec_cond[i] = {v[i], 1'b1};
         sec_en[i] = 2'h2;
      end
      settle();
   endtask : drive_src
   // ==========================================
   // scenarios
   task automatic t_reset();
      acc(1'b0, 1'b0, 1'b1, 4'h0, pic_pkg::MM_ALL_PEND, 32'h0);
      check("all_pend", rd, 32'h0);
      acc(1'b0, 1'b1, 1'b1, pic_pkg::CR_MASK, 8'h00, 32'h0);
      check("mask", rd, 32'h0);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_mask();
      drive_src(40'h00_0000_0020);
      acc(1'b0, 1'b0, 1'b1, 4'h0, pic_pkg::MM_ALL_PEND, 32'h0);
      check("all_pend", rd, 32'h20);
      check("normal_irq", normal_irq, 32'h0);
      acc(1'b1, 1'b0, 1'b1, 4'h0, pic_pkg::MM_MASK, 32'h20);
      acc(1'b0, 1'b0, 1'b1, 4'h0, pic_pkg::MM_MASK, 32'h0);
      check("mask_readback", rd, 32'h20);
      settle();
      check("normal_irq", normal_irq, 32'h1);
      drive_src(40'h0);
      check("normal_irq", normal_irq, 32'h0);
      $display("t_mask done");
   endtask : t_mask
   task automatic t_route();
      acc(1'b1, 1'b0, 1'b1, 4'h0, pic_pkg::MM_PRIO_LO_BASE, 32'h8000_0007);
      acc(1'b1, 1'b0, 1'b1, 4'h0, pic_pkg::MM_PRIO_LO_BASE + 8'h04, 32'h8000_0005);
      acc(1'b1, 1'b0, 1'b1, 4'h0, pic_pkg::MM_PRIO_LO_BASE + 8'h08, 32'h8000_0021);
      acc(1'b1, 1'b1, 1'b1, pic_pkg::CR_MASK, 8'h00, 32'h1A0);
      acc(1'b1, 1'b1, 1'b1, pic_pkg::CR_MASK2, 8'h00, 32'h2);
      acc(1'b1, 1'b1, 1'b1, pic_pkg::CR_LEVEL, 8'h00, 32'h80);
      acc(1'b0, 1'b0, 1'b1, 4'h0, pic_pkg::MM_MASK, 32'h0);
      check("mask_mm", rd, 32'h1A0);
      drive_src(40'h02_0000_00A0);
      check("fast_irq", fast_irq, 32'h1);
      check("normal_irq", normal_irq, 32'h1);
      acc(1'b0, 1'b0, 1'b1, 4'h0, pic_pkg::MM_FAST_PEND, 32'h0);
      check("fast_pend", rd, 32'h80);
      acc(1'b0, 1'b1, 1'b1, pic_pkg::CR_NORMAL_PEND2, 8'h00, 32'h0);
      check("normal_pend2", rd, 32'h2);
      acc(1'b0, 1'b1, 1'b1, pic_pkg::CR_HIGHEST, 8'h00, 32'h0);
      check("highest", rd, 32'h8005_8007);
      drive_src(40'h02_0000_0100);
      acc(1'b0, 1'b0, 1'b1, 4'h0, pic_pkg::MM_HIGHEST, 32'h0);
      check("highest", rd, 32'h8021_0000);
      acc(1'b1, 1'b0, 1'b1, 4'h0, pic_pkg::MM_PRIO_HI_BASE + 8'h1C, 32'h8000_0008);
      drive_src(40'h00_0000_0100);
      acc(1'b0, 1'b0, 1'b1, 4'h0, pic_pkg::MM_HIGHEST, 32'h0);
      check("highest", rd, 32'h8008_0000);
      drive_src(40'h0);
      acc(1'b0, 1'b0, 1'b1, 4'h0, pic_pkg::MM_HIGHEST, 32'h0);
      check("highest", rd, 32'h0);
      $display("t_route done");
   endtask : t_route
   task automatic t_access();
      acc(1'b1, 1'b1, 1'b0, pic_pkg::CR_MASK, 8'h00, 32'hFFFF_FFFF);
      check("undef", rsp.undef_err, 32'h1);
      acc(1'b1, 1'b0, 1'b0, 4'h0, pic_pkg::MM_MASK, 32'hFFFF_FFFF);
      check("abort", rsp.abort_err, 32'h1);
      acc(1'b0, 1'b1, 1'b1, 4'hB, 8'h00, 32'h0);
      check("undef", rsp.undef_err, 32'h1);
      acc(1'b0, 1'b1, 1'b1, pic_pkg::CR_MASK, 8'h00, 32'h0);
      check("mask", rd, 32'h1A0);
      acc(1'b0, 1'b0, 1'b1, 4'h0, pic_pkg::MM_CONTROL, 32'h0);
      check("control", rd, 32'h0);
      acc(1'b0, 1'b0, 1'b1, 4'h0, 8'hFC, 32'h0);
      check("unmapped_err", {rsp.undef_err, rsp.abort_err}, 32'h0);
      acc(1'b1, 1'b0, 1'b1, 4'h0, pic_pkg::MM_LEVEL2, 32'h2);
      drive_src(40'h02_0000_0000);
      check("fast_irq", fast_irq, 32'h1);
      check("normal_irq", normal_irq, 32'h0);
      acc(1'b0, 1'b1, 1'b1, pic_pkg::CR_FAST_PEND2, 8'h00, 32'h0);
      check("fast_pend2", rd, 32'h2);
      acc(1'b0, 1'b1, 1'b1, pic_pkg::CR_ALL_PEND2, 8'h00, 32'h0);
      check("all_pend2", rd, 32'h2);
      acc(1'b0, 1'b1, 1'b1, pic_pkg::CR_HIGHEST, 8'h00, 32'h0);
      check("highest", rd, 32'h0000_8021);
      drive_src(40'h0);
      $display("t_access done");
   endtask : t_access
   task automatic t_idle();
      core_idle = 1'b1;
      drive_src(40'h00_0000_0004);
      check("wake", wake, 32'h1);
      acc(1'b1, 1'b0, 1'b1, 4'h0, pic_pkg::MM_CONTROL, 32'h1);
      settle();
      check("wake", wake, 32'h0);
      drive_src(40'h00_0000_0024);
      check("wake", wake, 32'h1);
      core_idle = 1'b0;
      settle();
      check("wake", wake, 32'h0);
      drive_src(40'h0);
      $display("t_idle done");
   endtask : t_idle
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish
   // ==========================================
   // hang guard, far above the hundred or so cycles needed
   initial begin
      repeat (3000) @(posedge clk);
      fail_count++;
      tally_and_finish();
   end
   initial begin
      rst = 1'b1;
      core_idle = 1'b0;
      sec_cond = '0;
      sec_en = '0;
      req = '0;
      fail_count = 0;
      comparisons = 0;
      repeat (4) @(posedge clk);
      #1 rst = 1'b0;
      t_reset();
      t_mask();
      t_route();
      t_access();
      t_idle();
      tally_and_finish();
   end
endmodule : pic_top_test
`default_nettype wire
